// *** logic/ifsb_flag_bank.sv ***
/*
  Interrupt request flag bank with an APB slave, a sticky event status word,
  an event mask and one level interrupt output.
  Assumes request inputs come from logic on pclk, so they are not synchronised.
*/
`timescale 1ns/10ps

// Summary of operation
// - Flag reads one after a request or a write of one, else zero
// - Low word: capture1 bit5, timer1 bit4, pin0 bit3
// - Low word: sw1 bit2, sw0 bit1, core timer bit0
// - High word: usb bit25, flash event bit24
// - High word: dma channels 3..0 at bits 19..16
// - High word: rtc bit15, clock fail bit14
// - High word: i2c master, slave, collision 13..11
// - High word: uart tx, rx, error 10..8
// - High word: spi rx, tx, error 7..5
// - High word: comparators bits4,3; parallel port bit2
// - High word: adc bit1, pin change bit0
module ifsb_flag_bank (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ifsb_pkg::ADDR_W-1:0] paddr,
  input  wire logic [ifsb_pkg::DATA_W-1:0] pwdata,
  input  wire ifsb_pkg::ifsb_low_t      low_req,
  input  wire ifsb_pkg::ifsb_high_t     high_req,
  output logic [ifsb_pkg::DATA_W-1:0]   prdata,
  output logic                          pready,
  output logic                          pslverr,
  output ifsb_pkg::ifsb_low_t           flags_low,
  output ifsb_pkg::ifsb_high_t          flags_high,
  output logic                          irq
);
  import ifsb_pkg::*;

  function automatic logic [31:0] pack_low(input ifsb_low_t f);
    pack_low = {26'h0, f};
  endfunction : pack_low

  function automatic logic [31:0] pack_high(input ifsb_high_t f);
    pack_high = {6'h00, f[21:20], 4'h0, f[19:0]};
  endfunction : pack_high

  function automatic ifsb_high_t unpack_high(input logic [31:0] w);
    unpack_high = {w[25:24], w[19:0]};
  endfunction : unpack_high

  logic [31:0]       prdata_q;
  logic [31:0]       prdata_d;
  logic              pready_q;
  logic              pslverr_q;
  logic              irq_q;
  logic              irq_d;
  ifsb_low_t         flags_low_q;
  ifsb_low_t         flags_low_d;
  ifsb_high_t        flags_high_q;
  ifsb_high_t        flags_high_d;
  logic [EVT_W-1:0]  status_q;
  logic [EVT_W-1:0]  status_d;
  logic [EVT_W-1:0]  mask_q;
  logic [EVT_W-1:0]  mask_d;

  // Bus phase decode
  wire               setup      = psel & ~penable;
  wire               done       = psel & penable & pready_q;
  wire               wr_done    = done & pwrite;
  wire               rd_done    = done & ~pwrite;

  wire               sel_low    = (paddr == OFS_FLAGS_LOW);
  wire               sel_high   = (paddr == OFS_FLAGS_HIGH);
  wire               sel_status = (paddr == OFS_EVT_STATUS);
  wire               sel_mask   = (paddr == OFS_EVT_MASK);
  wire               mapped     = sel_low | sel_high | sel_status | sel_mask;

  wire               wr_low     = wr_done & sel_low;
  wire               wr_high    = wr_done & sel_high;
  wire               wr_mask    = wr_done & sel_mask;
  wire               rd_status  = rd_done & sel_status;

  wire [31:0]        low_word   = pack_low(flags_low_q);
  wire [31:0]        high_word  = pack_high(flags_high_q);
  wire [31:0]        evt_word   = {29'h0, status_q};
  wire [31:0]        mask_word  = {29'h0, mask_q};

  wire [31:0]        rd_word    = sel_low    ? low_word  :
                                  sel_high   ? high_word :
                                  sel_status ? evt_word  :
                                  sel_mask   ? mask_word : RDATA_RST;

  // Write value of one sets, zero clears; a request in the same cycle wins
  wire ifsb_low_t    wr_low_val  = pwdata[5:0];
  wire ifsb_high_t   wr_high_val = unpack_high(pwdata);
  wire ifsb_low_t    base_low    = wr_low  ? wr_low_val  : flags_low_q;
  wire ifsb_high_t   base_high   = wr_high ? wr_high_val : flags_high_q;

  // Events: a flag newly raised by its source, or a reserved-bit write to the high word
  wire               new_low    = |(low_req & ~flags_low_q);
  wire               new_high   = |(high_req & ~flags_high_q);
  wire               rsvd_wr    = wr_high & |(pwdata & ~HIGH_IMPL_MASK);

  wire [EVT_W-1:0]   evt_set    = {rsvd_wr, new_high, new_low};
  // Only bits that went out on the bus are cleared, so no event is lost
  wire [EVT_W-1:0]   evt_clr    = rd_status ? prdata_q[EVT_W-1:0] : EVT_RST;

  assign flags_low_d  = base_low | low_req;
  assign flags_high_d = base_high | high_req;
  assign status_d     = (status_q & ~evt_clr) | evt_set;
  assign mask_d       = wr_mask ? pwdata[EVT_W-1:0] : mask_q;
  assign irq_d        = |(status_d & mask_d);
  // Data is loaded in setup and zero otherwise, so it is stable for the access
  assign prdata_d     = (setup & ~pwrite) ? rd_word : RDATA_RST;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_low_q  <= LOW_RST;
      flags_high_q <= HIGH_RST;
    end
    else
    begin
      flags_low_q  <= flags_low_d;
      flags_high_q <= flags_high_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_q <= EVT_RST;
      mask_q   <= MASK_RST;
      irq_q    <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      mask_q   <= mask_d;
      irq_q    <= irq_d;
    end
  end

  // One wait-free access cycle: pready rises right after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= RDATA_RST;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q  <= prdata_d;
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign flags_low  = flags_low_q;
  assign flags_high = flags_high_q;
  assign irq        = irq_q;

  // Read of a flag word completes one cycle after setup
  wire rd_low_done  = rd_done & sel_low;
  wire rd_high_done = rd_done & sel_high;

  a_req_sets_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    (low_req.timer_one_flag || high_req.adc_done_flag)
      |=> (flags_low_q.timer_one_flag || !$past(low_req.timer_one_flag))
       && (flags_high_q.adc_done_flag || !$past(high_req.adc_done_flag)))
    else $error("Request did not raise its flag");

  a_low_hi_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && sel_low
      |=> prdata_q[5:3] == $past({flags_low_q.capture1_flag,
                                  flags_low_q.timer_one_flag,
                                  flags_low_q.ext_pin0_flag}))
    else $error("Low word bits 5..3 misplaced");

  a_low_lo_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && sel_low
      |=> prdata_q[2:0] == $past({flags_low_q.core_sw1_flag,
                                  flags_low_q.core_sw0_flag,
                                  flags_low_q.core_timer_flag})
       && prdata_q[31:6] == 26'h0)
    else $error("Low word bits 2..0 misplaced");

  a_rsvd_read_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_high_done |-> (prdata_q & ~HIGH_IMPL_MASK) == 32'h00000000)
    else $error("Reserved high bits read nonzero");

  a_usb_flash_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && sel_high
      |=> prdata_q[25:24] == $past({flags_high_q.usb_request_flag,
                                    flags_high_q.flash_event_flag}))
    else $error("Usb or flash bit misplaced");

  a_dma_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_high && !high_req.dma_ch3_flag && !high_req.dma_ch0_flag
      |=> flags_high_q.dma_ch3_flag == $past(pwdata[19])
       && flags_high_q.dma_ch0_flag == $past(pwdata[16]))
    else $error("Dma flag write misplaced");

  a_rtc_fail_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_high_done
      |-> prdata_q[15:14] == $past({flags_high_q.rtc_alarm_flag,
                                    flags_high_q.clock_fail_flag}))
    else $error("Rtc or clock fail bit misplaced");

  a_i2c_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_high_done
      |-> prdata_q[13:11] == $past({flags_high_q.i2c_b_master_flag,
                                    flags_high_q.i2c_b_slave_flag,
                                    flags_high_q.i2c_b_collision_flag}))
    else $error("I2c bits misplaced");

  a_uart_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_high_done
      |-> prdata_q[10:8] == $past({flags_high_q.uart_b_tx_flag,
                                   flags_high_q.uart_b_rx_flag,
                                   flags_high_q.uart_b_error_flag}))
    else $error("Uart bits misplaced");

  a_spi_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_high_done
      |-> prdata_q[7:5] == $past({flags_high_q.spi_b_rx_flag,
                                  flags_high_q.spi_b_tx_flag,
                                  flags_high_q.spi_b_error_flag}))
    else $error("Spi bits misplaced");

  a_cmp_pmp_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_high_done
      |-> prdata_q[4:2] == $past({flags_high_q.comparator_b_flag,
                                  flags_high_q.comparator_a_flag,
                                  flags_high_q.parallel_port_flag}))
    else $error("Comparator or port bits misplaced");

  a_adc_cn_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_high_done
      |-> prdata_q[1:0] == $past({flags_high_q.adc_done_flag,
                                  flags_high_q.pin_change_flag}))
    else $error("Adc or change bits misplaced");

  a_flag_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    flags_low_q.core_timer_flag && !wr_low
      |=> flags_low_q.core_timer_flag [*1])
    else $error("Flag dropped without a write");

  a_write_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_low && !pwdata[4] && !low_req.timer_one_flag
      |=> !flags_low_q.timer_one_flag)
    else $error("Write of zero did not clear flag");

  a_irq_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 irq_q == |($past(status_d) & $past(mask_d)))
    else $error("Interrupt output out of step");

  a_bus_answer: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready_q ##1 !pready_q)
    else $error("Ready not a one cycle answer");

  // Write, event, interrupt, error and idle paths, which a flag map check alone never trips
  a_req_beats_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_low && low_req.core_timer_flag
      |=> flags_low_q.core_timer_flag)
    else $error("Clearing write beat a request");

  a_write_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_high && pwdata[25] && pwdata[24]
      |=> flags_high_q.usb_request_flag && flags_high_q.flash_event_flag)
    else $error("Write of one did not set flag");

  a_low_event: assert property (
    @(posedge pclk) disable iff (!presetn)
    low_req.capture1_flag && !flags_low_q.capture1_flag
      |=> status_q[EVT_LOW_BIT])
    else $error("New low flag left no event");

  a_high_event: assert property (
    @(posedge pclk) disable iff (!presetn)
    high_req.pin_change_flag && !flags_high_q.pin_change_flag
      |=> status_q[EVT_HIGH_BIT])
    else $error("New high flag left no event");

  a_rsvd_event: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_high && pwdata[31:26] != 6'h00
      |=> status_q[EVT_RSVD_BIT])
    else $error("Reserved write left no event");

  a_status_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_status && !new_low && !new_high && !rsvd_wr
      |=> (status_q & $past(prdata_q[EVT_W-1:0])) == EVT_RST)
    else $error("Status read did not clear bits");

  a_irq_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_q == |(status_q & mask_q))
    else $error("Interrupt output disagrees with status");

  a_unmapped_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !mapped
      |=> pslverr_q && prdata_q == RDATA_RST)
    else $error("Unmapped access not refused");

  a_mapped_ok: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && mapped
      |=> !pslverr_q)
    else $error("Mapped access flagged as error");

  a_unmapped_nowr: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_done && !mapped && high_req == HIGH_RST
      |=> flags_high_q == $past(flags_high_q))
    else $error("Unmapped write changed flags");

  a_data_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pready_q |-> prdata_q == RDATA_RST && !pslverr_q)
    else $error("Bus outputs not idle outside access");

endmodule : ifsb_flag_bank

// *** include/ifsb_pkg.sv ***
/*
  Shared definitions of the interrupt flag bank: register offsets, field
  layouts of both flag words, event status bits and reset values.
  Assumes an APB slave with a 12-bit byte address and 32-bit data.
*/
package ifsb_pkg;

  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;

  // Byte offsets of the four words
  localparam logic [11:0] OFS_FLAGS_LOW   = 12'h000;
  localparam logic [11:0] OFS_FLAGS_HIGH  = 12'h004;
  localparam logic [11:0] OFS_EVT_STATUS  = 12'h008;
  localparam logic [11:0] OFS_EVT_MASK    = 12'h00c;

  // Implemented bits of each flag word; all others read zero
  localparam logic [31:0] LOW_IMPL_MASK   = 32'h0000003f;
  localparam logic [31:0] HIGH_IMPL_MASK  = 32'h030fffff;

  // Event status and mask layout
  localparam int          EVT_W           = 3;
  localparam int          EVT_LOW_BIT     = 0;
  localparam int          EVT_HIGH_BIT    = 1;
  localparam int          EVT_RSVD_BIT    = 2;

  localparam logic [2:0]  EVT_RST         = 3'h0;
  localparam logic [2:0]  MASK_RST        = 3'h0;
  localparam logic [31:0] RDATA_RST       = 32'h00000000;

  // Low flag word, bits 5 down to 0
  typedef struct packed {
    logic capture1_flag;
    logic timer_one_flag;
    logic ext_pin0_flag;
    logic core_sw1_flag;
    logic core_sw0_flag;
    logic core_timer_flag;
  } ifsb_low_t;

  // High flag word, bits 25..24 then 19 down to 0
  typedef struct packed {
    logic usb_request_flag;
    logic flash_event_flag;
    logic dma_ch3_flag;
    logic dma_ch2_flag;
    logic dma_ch1_flag;
    logic dma_ch0_flag;
    logic rtc_alarm_flag;
    logic clock_fail_flag;
    logic i2c_b_master_flag;
    logic i2c_b_slave_flag;
    logic i2c_b_collision_flag;
    logic uart_b_tx_flag;
    logic uart_b_rx_flag;
    logic uart_b_error_flag;
    logic spi_b_rx_flag;
    logic spi_b_tx_flag;
    logic spi_b_error_flag;
    logic comparator_b_flag;
    logic comparator_a_flag;
    logic parallel_port_flag;
    logic adc_done_flag;
    logic pin_change_flag;
  } ifsb_high_t;

  localparam ifsb_low_t   LOW_RST         = 6'h00;
  localparam ifsb_high_t  HIGH_RST        = 22'h000000;

endpackage : ifsb_pkg

// *** tb/ifsb_req_model.sv ***
/*
  Model of the peripherals and core that raise interrupt requests.
  Assumes a command from the bench (fire, src) on pclk; answers with a
  one-cycle request pulse on the matching source bit, the next cycle.
*/
`timescale 1ns/10ps

module ifsb_req_model (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            fire,
  input  wire logic [4:0]      src,
  output ifsb_pkg::ifsb_low_t  low_req,
  output ifsb_pkg::ifsb_high_t high_req
);
  import ifsb_pkg::*;

  logic [27:0] hot;

  // Sources 0..5 feed the low word, 6..27 the high struct in order
  assign hot = fire ? (28'h1 << src) : 28'h0;

  // Pulse, not level: proves the flag holds the request on its own
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      low_req  <= LOW_RST;
      high_req <= HIGH_RST;
    end
    else
    begin
      low_req  <= hot[5:0];
      high_req <= hot[27:6];
    end
endmodule : ifsb_req_model

// *** tb/ifsb_flag_bank_tb.sv ***
/*
  Self-checking bench of the interrupt flag bank: APB master tasks,
  request model, per-source, write, refusal and interrupt scenarios.
  Assumes the pready timing and offsets stated with the design.
*/
`timescale 1ns/10ps

module interrupt_flag_status_bank_tb;
  import ifsb_pkg::*;

  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [4:0]  src = 5'h00;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq, er;
  ifsb_low_t   low_req, flags_low;
  ifsb_high_t  high_req, flags_high;
  int          fails = 0, cmp_count = 0;

  always #20 pclk = ~pclk;

  ifsb_flag_bank DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .low_req(low_req),
    .high_req(high_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flags_low(flags_low), .flags_high(flags_high), .irq(irq));

  ifsb_req_model srcs (.pclk(pclk), .presetn(presetn), .fire(fire), .src(src),
    .low_req(low_req), .high_req(high_req));

  task results;
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request held until pready is sampled high, then released
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      fails++;
      $display("[ERR] %0t no pready", $time);
      results();
    end
  endtask : apb

  task reset_values;
    for (int a = 0; a < 16; a += 4)
    begin
      apb(1'b0, 12'(a), 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, er}, 32'h0);
    end
  endtask : reset_values

  task each_source;
    logic [31:0] exp;
    logic [11:0] ofs;
    apb(1'b1, OFS_EVT_MASK, 32'h00000007);
    for (int i = 0; i < 28; i++)
    begin
      exp = i < 6 ? 32'h1 << i : (i < 26 ? 32'h1 << (i - 6) : 32'h1 << (i - 2));
      ofs = i < 6 ? OFS_FLAGS_LOW : OFS_FLAGS_HIGH;
      @(posedge pclk);
      src <= 5'(i);
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, ofs, 32'h0);
      chk(rd, exp);
      apb(1'b0, ofs, 32'h0);
      chk(rd, exp);
      apb(1'b0, OFS_EVT_STATUS, 32'h0);
      chk(rd, i < 6 ? 32'h1 : 32'h2);
      // The clearing edge launches the drop of irq, so look one edge later
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, ofs, 32'h0);
      apb(1'b0, ofs, 32'h0);
      chk(rd, 32'h0);
    end
  endtask : each_source

  task write_and_refuse;
    apb(1'b1, OFS_FLAGS_LOW, 32'hffffffff);
    apb(1'b0, OFS_FLAGS_LOW, 32'h0);
    chk(rd, LOW_IMPL_MASK);
    apb(1'b1, OFS_FLAGS_HIGH, 32'hffffffff);
    apb(1'b0, OFS_FLAGS_HIGH, 32'h0);
    chk(rd, HIGH_IMPL_MASK);
    chk({10'h0, flags_high}, 32'h003fffff);
    chk({26'h0, flags_low}, LOW_IMPL_MASK);
    apb(1'b0, OFS_EVT_STATUS, 32'h0);
    chk(rd, 32'h4);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h010, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask : write_and_refuse

  task masked_event;
    apb(1'b1, OFS_FLAGS_HIGH, 32'h0);
    apb(1'b1, OFS_EVT_MASK, 32'h0);
    @(posedge pclk);
    src <= 5'h06;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, OFS_EVT_STATUS, 32'h0);
    chk(rd, 32'h2);
  endtask : masked_event

  // Flags left set by earlier scenarios must vanish with a reset in mid-run
  task mid_reset;
    chk({26'h0, flags_low}, LOW_IMPL_MASK);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({10'h0, flags_high}, 32'h0);
    chk({31'h0, pready}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, OFS_FLAGS_LOW, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_FLAGS_HIGH, 32'h0);
    chk(rd, 32'h0);
  endtask : mid_reset

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    reset_values();
    each_source();
    write_and_refuse();
    masked_event();
    mid_reset();
    results();
  end
endmodule : interrupt_flag_status_bank_tb
